// *** inc/tscx_consts.vh ***
/*
  tscx_consts.vh: register offsets, field positions, command encodings and
  reset values for the trigger step command executor.
  assumes: included by bare name, definitions only.
*/
`ifndef TSCX_CONSTS_VH
`define TSCX_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TSCX_OFF_BTE      6'h00
`define TSCX_OFF_CTRL     6'h04
`define TSCX_OFF_ADJ      6'h08
`define TSCX_OFF_HOLD     6'h0c
`define TSCX_OFF_C0LIM    6'h10
`define TSCX_OFF_C1LIM    6'h14
`define TSCX_OFF_T0LIM    6'h18
`define TSCX_OFF_T1LIM    6'h1c
`define TSCX_OFF_SDLIM    6'h20
`define TSCX_OFF_LIT0     6'h24
`define TSCX_OFF_ADCSEL   6'h28
`define TSCX_OFF_STATUS   6'h2c
`define TSCX_OFF_CMD      6'h30

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TSCX_CTRL_EN      0
`define TSCX_CTRL_STRT    1
`define TSCX_CTRL_SWT     2

// ----------------------------------------
// broadcast enable fields
// ----------------------------------------
`define TSCX_BTE_OC1CLK   4

// ----------------------------------------
// command groups (cmd[7:4]) and options
// ----------------------------------------
`define TSCX_GRP_CTRL     4'h0
`define TSCX_GRP_ADD      4'h1
`define TSCX_GRP_COPY     4'h2
`define TSCX_OPT_SD_OFF   4'h2
`define TSCX_OPT_SD_ON    4'h6
`define TSCX_OPT_T0_WAIT  4'h8
`define TSCX_OPT_T1_WAIT  4'h9
`define TSCX_OPT_SWT_WAIT 4'hb
`define TSCX_OPT_CNT0_ADC 4'hc
`define TSCX_OPT_CNT1_ADC 4'hd
`define TSCX_OPT_LIT_ADC  4'he
`define TSCX_OPT_BCAST    4'hf

// ----------------------------------------
// reset values and AXI response codes
// ----------------------------------------
`define TSCX_RST_WORD     16'h0000
`define TSCX_AXI_OKAY     2'b00
`define TSCX_AXI_SLVERR   2'b10

`endif

// *** rtl/tscx_match_timer.v ***
/*
  tscx_match_timer.v: one sequencer timer; counts up from zero after start
  and flags when it equals its limit.
  assumes: start is a one-cycle pulse in the aclk domain.
*/
`timescale 1ns/100ps
`include "tscx_consts.vh"

module tscx_match_timer (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire [15:0] limit,
  output reg running,
  output reg match
);

  reg [15:0] count;

  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= `TSCX_RST_WORD;
      running <= 1'b0;
      match <= 1'b0;
    end else if (start) begin
      count <= `TSCX_RST_WORD;
      running <= 1'b1;
      match <= 1'b0;
    end else if (running) begin
      // compare before advancing so a zero limit matches at once
      if (count == limit) begin
        running <= 1'b0;
        match <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end else begin
      match <= 1'b0;
    end
  end

endmodule // tscx_match_timer

// *** rtl/tscx_axil_slave.v ***
/*
  tscx_axil_slave.v: AXI4-Lite slave front end; turns bus transfers into
  single-cycle write and read strobes with a byte address.
  assumes: rdata is valid in the cycle after rd_stb.
*/
`timescale 1ns/100ps
`include "tscx_consts.vh"

module tscx_axil_slave (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output wire s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output wire s_axil_wready,
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  input wire [5:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output wire s_axil_arready,
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready,
  output wire wr_stb,
  output wire [5:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  input wire wr_ok,
  output wire rd_stb,
  output wire [5:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_ok
);

  reg aw_held;
  reg w_held;
  reg [5:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] s_q;
  reg rd_pend;

  // address and data may arrive in either order; each is latched once
  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready = !w_held && !s_axil_bvalid;
  assign wr_stb = aw_held && w_held;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign wr_strb = s_q;
  assign s_axil_arready = !rd_pend && !s_axil_rvalid;
  assign rd_stb = s_axil_arvalid && s_axil_arready;
  assign rd_addr = s_axil_araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 6'h00;
      w_q <= 32'h00000000;
      s_q <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `TSCX_AXI_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held <= 1'b1;
        w_q <= s_axil_wdata;
        s_q <= s_axil_wstrb;
      end
      if (wr_stb) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_ok ? `TSCX_AXI_OKAY : `TSCX_AXI_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= `TSCX_AXI_OKAY;
    end else if (rd_stb) begin
      rd_pend <= 1'b1;
    end else if (rd_pend) begin
      rd_pend <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_data;
      s_axil_rresp <= rd_ok ? `TSCX_AXI_OKAY : `TSCX_AXI_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

endmodule // tscx_axil_slave

// *** rtl/tscx_executor.v ***
/*
  tscx_executor.v: trigger sequencer step command executor for the control,
  add and copy groups, with its registers on AXI4-Lite.
  assumes: the step fetcher offers cmd with cmd_valid and holds it until
  cmd_ready; trigger outputs feed compare units as one-cycle pulses.
*/
// The AXI4-Lite slave port and the address map were decided locally.
// Functional notes
// [R1] the broadcast command pulses exactly the trigger outputs enabled in the broadcast enable register
// [R2] enable bit 4 sends one clock pulse to compare unit 1 per broadcast, none when clear
// [R3] enable bits 3..0 gate sync pulses to compare units 4, 3, 2 and 1 on a broadcast
// [R4] while module enable and sequence start are both set, writes to the broadcast enable register are ignored
// [R5] only the broadcast command consults the broadcast enable register
// [R6] control option 0010 disables and 0110 enables the step delay timer
// [R7] control option 1000 starts timer 0 and waits for it to match its limit
// [R8] control option 1001 starts timer 1 and waits for it to match its limit
// [R9] control option 1011 waits for a rising edge of the software trigger bit, which software must supply
// [R10] control option 1100 copies counter 0 into the adc channel 0 select register
// [R11] control option 1101 copies counter 1 into the adc channel 0 select register
// [R12] control option 1110 copies literal 0 into the adc channel 0 select register
// [R13] add options 0000..0101 add the adjust value to the six limit and literal registers in order
// [R14] copy options 1000..1101 load the hold value into the six limit and literal registers in order
// [R15] reserved options complete as no-operations
// [R16] additions wrap modulo sixteen bits with no flag
`timescale 1ns/100ps
`include "tscx_consts.vh"

module tscx_executor (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output wire s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output wire s_axil_wready,
  output wire [1:0] s_axil_bresp,
  output wire s_axil_bvalid,
  input wire s_axil_bready,
  input wire [5:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output wire s_axil_arready,
  output wire [31:0] s_axil_rdata,
  output wire [1:0] s_axil_rresp,
  output wire s_axil_rvalid,
  input wire s_axil_rready,
  input wire [7:0] cmd,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [15:0] counter0_value,
  input wire [15:0] counter1_value,
  output reg step_delay_enable,
  output reg [3:0] compare_sync_pulse,
  output reg compare1_clock_pulse,
  output reg [15:0] adc_channel0_select
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_T0 = 4'b0010;
  localparam [3:0] ST_T1 = 4'b0100;
  localparam [3:0] ST_SWT = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [15:0] broadcast_trigger_enable;
  reg module_enable;
  reg sequence_start;
  reg software_trigger_bit;
  reg swt_prev;
  reg [15:0] adjust_value;
  reg [15:0] hold_value;
  reg [15:0] lim [0:5];
  reg [7:0] last_cmd;
  reg [15:0] cmd_count;
  reg [15:0] rd_mux;
  reg rd_hit;
  reg wr_hit;

  wire wr_stb;
  wire [5:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_stb;
  wire [5:0] rd_addr;
  wire t0_run;
  wire t0_match;
  wire t1_run;
  wire t1_match;
  wire [3:0] grp = cmd[7:4];
  wire [3:0] opt = cmd[3:0];
  wire idle = (state == ST_IDLE);
  wire take = cmd_valid && idle;
  wire ctl_cmd = take && (grp == `TSCX_GRP_CTRL);
  wire add_cmd = take && (grp == `TSCX_GRP_ADD) && (opt[3:1] != 3'b011) && !opt[3];
  wire copy_cmd = take && (grp == `TSCX_GRP_COPY) && opt[3] && (opt[2:1] != 2'b11);
  wire [2:0] dst = {1'b0, opt[2:0]} > 4'h5 ? 3'h0 : opt[2:0];
  wire bte_locked = module_enable && sequence_start;
  wire swt_rise = software_trigger_bit && !swt_prev;

  // waits finish in the cycle their event appears; others finish on take
  assign cmd_ready = take && !(ctl_cmd && (opt == `TSCX_OPT_T0_WAIT || opt == `TSCX_OPT_T1_WAIT ||
                     opt == `TSCX_OPT_SWT_WAIT)) || (state == ST_T0 && t0_match) ||
                     (state == ST_T1 && t1_match) || (state == ST_SWT && swt_rise);

  tscx_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_hit),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data({16'h0000, rd_mux}),
    .rd_ok(rd_hit)
  );

  tscx_match_timer u_t0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ctl_cmd && opt == `TSCX_OPT_T0_WAIT), // R7
    .limit(lim[2]),
    .running(t0_run),
    .match(t0_match)
  );

  tscx_match_timer u_t1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ctl_cmd && opt == `TSCX_OPT_T1_WAIT), // R8
    .limit(lim[3]),
    .running(t1_run),
    .match(t1_match)
  );

  // ----------------------------------------
  // register address decode
  // ----------------------------------------
  reg [5:0] rd_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= 6'h00;
    end else if (rd_stb) begin
      rd_q <= rd_addr;
    end
  end

  always @* begin
    wr_hit = (wr_addr <= `TSCX_OFF_LIT0) && (wr_addr[1:0] == 2'b00);
    rd_hit = 1'b1;
    case (rd_q)
      `TSCX_OFF_BTE: rd_mux = broadcast_trigger_enable;
      `TSCX_OFF_CTRL: rd_mux = {13'h0000, software_trigger_bit, sequence_start, module_enable};
      `TSCX_OFF_ADJ: rd_mux = adjust_value;
      `TSCX_OFF_HOLD: rd_mux = hold_value;
      `TSCX_OFF_C0LIM: rd_mux = lim[0];
      `TSCX_OFF_C1LIM: rd_mux = lim[1];
      `TSCX_OFF_T0LIM: rd_mux = lim[2];
      `TSCX_OFF_T1LIM: rd_mux = lim[3];
      `TSCX_OFF_SDLIM: rd_mux = lim[4];
      `TSCX_OFF_LIT0: rd_mux = lim[5];
      `TSCX_OFF_ADCSEL: rd_mux = adc_channel0_select;
      `TSCX_OFF_STATUS: rd_mux = {8'h00, t1_run, t0_run, step_delay_enable, 1'b0, state};
      `TSCX_OFF_CMD: rd_mux = {cmd_count[7:0], last_cmd};
      default: begin
        rd_mux = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ctl_cmd && opt == `TSCX_OPT_T0_WAIT) begin
          next_state = ST_T0; // R7
        end else if (ctl_cmd && opt == `TSCX_OPT_T1_WAIT) begin
          next_state = ST_T1; // R8
        end else if (ctl_cmd && opt == `TSCX_OPT_SWT_WAIT) begin
          next_state = ST_SWT; // R9
        end
      end
      ST_T0: if (t0_match) next_state = ST_IDLE; // R7
      ST_T1: if (t1_match) next_state = ST_IDLE; // R8
      ST_SWT: if (swt_rise) next_state = ST_IDLE; // R9
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      swt_prev <= 1'b0;
    end else begin
      state <= next_state;
      swt_prev <= software_trigger_bit; // R9
    end
  end

  // ----------------------------------------
  // software registers and command effects
  // ----------------------------------------
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      broadcast_trigger_enable <= `TSCX_RST_WORD;
      module_enable <= 1'b0;
      sequence_start <= 1'b0;
      software_trigger_bit <= 1'b0;
      adjust_value <= `TSCX_RST_WORD;
      hold_value <= `TSCX_RST_WORD;
      for (i = 0; i < 6; i = i + 1) begin
        lim[i] <= `TSCX_RST_WORD;
      end
    end else begin
      if (wr_stb && wr_strb[1:0] == 2'b11) begin
        case (wr_addr)
          `TSCX_OFF_BTE: if (!bte_locked) broadcast_trigger_enable <= wr_data[15:0]; // R4
          `TSCX_OFF_CTRL: begin
            module_enable <= wr_data[`TSCX_CTRL_EN];
            sequence_start <= wr_data[`TSCX_CTRL_STRT];
            software_trigger_bit <= wr_data[`TSCX_CTRL_SWT];
          end
          `TSCX_OFF_ADJ: adjust_value <= wr_data[15:0];
          `TSCX_OFF_HOLD: hold_value <= wr_data[15:0];
          `TSCX_OFF_C0LIM: lim[0] <= wr_data[15:0];
          `TSCX_OFF_C1LIM: lim[1] <= wr_data[15:0];
          `TSCX_OFF_T0LIM: lim[2] <= wr_data[15:0];
          `TSCX_OFF_T1LIM: lim[3] <= wr_data[15:0];
          `TSCX_OFF_SDLIM: lim[4] <= wr_data[15:0];
          `TSCX_OFF_LIT0: lim[5] <= wr_data[15:0];
          default: ;
        endcase
      end
      // command update wins over a same-cycle software write
      if (add_cmd) begin
        lim[dst] <= lim[dst] + adjust_value; // R13 R16
      end
      if (copy_cmd) begin
        lim[dst] <= hold_value; // R14
      end
    end
  end

  // reserved options fall through every case below untouched
  always @(posedge aclk) begin
    if (!aresetn) begin
      step_delay_enable <= 1'b0;
      compare_sync_pulse <= 4'h0;
      compare1_clock_pulse <= 1'b0;
      adc_channel0_select <= `TSCX_RST_WORD;
      last_cmd <= 8'h00;
      cmd_count <= 16'h0000;
    end else begin
      compare_sync_pulse <= 4'h0;
      compare1_clock_pulse <= 1'b0;
      if (cmd_ready) begin
        last_cmd <= cmd; // R15
        cmd_count <= cmd_count + 16'h0001;
      end
      if (ctl_cmd) begin
        case (opt)
          `TSCX_OPT_SD_OFF: step_delay_enable <= 1'b0; // R6
          `TSCX_OPT_SD_ON: step_delay_enable <= 1'b1; // R6
          `TSCX_OPT_CNT0_ADC: adc_channel0_select <= counter0_value; // R10
          `TSCX_OPT_CNT1_ADC: adc_channel0_select <= counter1_value; // R11
          `TSCX_OPT_LIT_ADC: adc_channel0_select <= lim[5]; // R12
          `TSCX_OPT_BCAST: begin
            compare_sync_pulse <= broadcast_trigger_enable[3:0]; // R1 R3 R5
            compare1_clock_pulse <= broadcast_trigger_enable[`TSCX_BTE_OC1CLK]; // R1 R2
          end
          default: ; // R15
        endcase
      end
    end
  end

endmodule // tscx_executor

// *** dv/tscx_chk.sv ***
/*
  tscx_chk.sv: assertions on the command port and trigger outputs of tscx_executor.
  assumes: bound into tscx_executor; one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps

module tscx_chk (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] cmd,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [15:0] counter0_value,
  input wire [15:0] counter1_value,
  input wire step_delay_enable,
  input wire [3:0] compare_sync_pulse,
  input wire compare1_clock_pulse,
  input wire [15:0] adc_channel0_select
);
  wire done = cmd_valid && cmd_ready;
  wire bcast = done && cmd == 8'h0f;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sync_cause; compare_sync_pulse != 4'h0 |-> $past(bcast); endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync pulse without broadcast");
  property p_clk_cause; compare1_clock_pulse |-> $past(bcast); endproperty
  a_clk_cause: assert property (p_clk_cause) else $error("clock pulse without broadcast");
  property p_bcast_once; bcast ##1 !done |=> compare_sync_pulse == 4'h0 && !compare1_clock_pulse; endproperty
  a_bcast_once: assert property (p_bcast_once) else $error("trigger pulse longer than one cycle");
  property p_sd_off; done && cmd == 8'h02 |=> !step_delay_enable; endproperty
  a_sd_off: assert property (p_sd_off) else $error("step delay not disabled");
  property p_sd_on; done && cmd == 8'h06 |=> step_delay_enable; endproperty
  a_sd_on: assert property (p_sd_on) else $error("step delay not enabled");
  property p_sd_keep; $changed(step_delay_enable) |-> $past(done && (cmd == 8'h02 || cmd == 8'h06)); endproperty
  a_sd_keep: assert property (p_sd_keep) else $error("step delay changed by other command");
  property p_adc_c0; done && cmd == 8'h0c |=> adc_channel0_select == $past(counter0_value); endproperty
  a_adc_c0: assert property (p_adc_c0) else $error("adc select not counter 0");
  property p_adc_c1; done && cmd == 8'h0d |=> adc_channel0_select == $past(counter1_value); endproperty
  a_adc_c1: assert property (p_adc_c1) else $error("adc select not counter 1");
  property p_adc_keep; $changed(adc_channel0_select) |-> $past(done && cmd[7:2] == 6'h03 && cmd[1:0] != 2'b11);
  endproperty
  a_adc_keep: assert property (p_adc_keep) else $error("adc select changed by other command");
  property p_wait_stall; $rose(cmd_valid) && (cmd == 8'h08 || cmd == 8'h09 || cmd == 8'h0b) |-> !cmd_ready;
  endproperty
  a_wait_stall: assert property (p_wait_stall) else $error("wait command did not stall");
  property p_quick; $rose(cmd_valid) && cmd[7:4] != 4'h0 |-> cmd_ready; endproperty
  a_quick: assert property (p_quick) else $error("add or copy command stalled");

  c_bcast: cover property (bcast && compare_sync_pulse == 4'h0);
  c_t0: cover property (done && cmd == 8'h08);
  c_swt: cover property (done && cmd == 8'h0b);
endmodule // tscx_chk

bind tscx_executor tscx_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .counter0_value(counter0_value), .counter1_value(counter1_value), .step_delay_enable(step_delay_enable),
  .compare_sync_pulse(compare_sync_pulse), .compare1_clock_pulse(compare1_clock_pulse),
  .adc_channel0_select(adc_channel0_select)
);

// *** dv/tscx_peer.sv ***
/*
  tscx_peer.sv: compare units and counters at the far side; counts trigger pulses.
  assumes: same clock and reset as the executor.
*/
`timescale 1ns/100ps

module tscx_peer (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] compare_sync_pulse,
  input wire compare1_clock_pulse,
  output logic [15:0] counter0_value,
  output logic [15:0] counter1_value,
  output int sync_total,
  output int clock_total
);
  // counters move every cycle so a stale copy is caught
  always @(posedge aclk) begin
    if (!aresetn) begin
      counter0_value <= 16'h0000;
      counter1_value <= 16'h0000;
      sync_total <= 0;
      clock_total <= 0;
    end else begin
      counter0_value <= counter0_value + 16'h0001;
      counter1_value <= counter1_value - 16'h0003;
      sync_total <= sync_total + $countones(compare_sync_pulse);
      clock_total <= clock_total + int'(compare1_clock_pulse);
    end
  end
endmodule // tscx_peer

// *** dv/tb_top.sv ***
/*
  tb_top.sv: self-checking bench for tscx_executor over AXI4-Lite and the command port.
  assumes: tscx_consts.vh on the include path; peer model in tscx_peer.sv.
*/
`timescale 1ns/100ps
`include "tscx_consts.vh"

module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [5:0] s_axil_awaddr = 6'h00, s_axil_araddr = 6'h00;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
  logic s_axil_rready = 1'b0, cmd_valid = 1'b0;
  logic [31:0] s_axil_wdata = 32'h0, rd, v, seed = 32'h11a8fcbe;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic [7:0] cmd = 8'h00;
  logic [1:0] resp;
  logic [15:0] c0_at, c1_at, a, b;
  logic [5:0] offs [6] = '{`TSCX_OFF_C0LIM, `TSCX_OFF_C1LIM, `TSCX_OFF_T0LIM, `TSCX_OFF_T1LIM,
                           `TSCX_OFF_SDLIM, `TSCX_OFF_LIT0};
  logic [7:0] rsvd [12] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0a, 8'h16, 8'h17, 8'h2e, 8'h2f, 8'h3f};
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, cmd_ready;
  wire step_delay_enable, compare1_clock_pulse;
  wire [1:0] s_axil_bresp, s_axil_rresp;
  wire [31:0] s_axil_rdata;
  wire [15:0] counter0_value, counter1_value, adc_channel0_select;
  wire [3:0] compare_sync_pulse;
  int sync_total, clock_total, n, fails = 0, cmp_count = 0, cyc = 0, exp_sync = 0, exp_clock = 0;

  tscx_executor DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .counter0_value(counter0_value),
    .counter1_value(counter1_value), .step_delay_enable(step_delay_enable),
    .compare_sync_pulse(compare_sync_pulse), .compare1_clock_pulse(compare1_clock_pulse),
    .adc_channel0_select(adc_channel0_select)
  );

  tscx_peer u_peer (
    .aclk(aclk), .aresetn(aresetn), .compare_sync_pulse(compare_sync_pulse),
    .compare1_clock_pulse(compare1_clock_pulse), .counter0_value(counter0_value),
    .counter1_value(counter1_value), .sync_total(sync_total), .clock_total(clock_total)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] exp_sum(input logic [15:0] x, input logic [15:0] y);
    logic [15:0] s;
    s = x + y;
    return {16'h0000, s};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [5:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axil_awaddr <= ad;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready)
        s_axil_awvalid <= 1'b0;
      if (s_axil_wready)
        s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    resp = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [5:0] ad);
    @(posedge aclk);
    s_axil_araddr <= ad;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready)
        s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    rd = s_axil_rdata;
    resp = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  // counter values are captured at the taking edge, as the executor sees them
  task automatic run_cmd(input logic [7:0] c);
    @(posedge aclk);
    cmd <= c;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      c0_at = counter0_value;
      c1_at = counter1_value;
    end while (!cmd_ready);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // hang guard; the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      axi_rd(6'(i * 4));
      check("reset value", rd, (i * 4 == `TSCX_OFF_STATUS) ? 32'h1 : 32'h0);
    end
    axi_rd(6'h34);
    check("unmapped read resp", resp, `TSCX_AXI_SLVERR);
    axi_wr(6'h3c, 32'h1);
    check("unmapped write resp", resp, `TSCX_AXI_SLVERR);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f : rnd() & 32'h1f;
      axi_wr(`TSCX_OFF_BTE, v);
      run_cmd(8'h0f);
      check("sync pulses", compare_sync_pulse, v[3:0]);
      check("clock pulse", compare1_clock_pulse, v[4]);
      exp_sync += $countones(v[3:0]);
      exp_clock += int'(v[4]);
      run_cmd(8'h02);
      check("no pulse on other", compare_sync_pulse, 4'h0);
      check("delay off", step_delay_enable, 1'b0);
      run_cmd(8'h06);
      check("delay on", step_delay_enable, 1'b1);
    end
    check("peer sync count", sync_total, exp_sync);
    check("peer clock count", clock_total, exp_clock);
    axi_wr(`TSCX_OFF_BTE, 32'h15);
    axi_wr(`TSCX_OFF_CTRL, 32'h3);
    axi_wr(`TSCX_OFF_BTE, 32'h0a);
    check("locked write resp", resp, `TSCX_AXI_OKAY);
    axi_rd(`TSCX_OFF_BTE);
    check("bte locked", rd, 32'h15);
    axi_wr(`TSCX_OFF_CTRL, 32'h1);
    axi_wr(`TSCX_OFF_BTE, 32'h0a);
    axi_rd(`TSCX_OFF_BTE);
    check("bte open", rd, 32'h0a);
    axi_wr(`TSCX_OFF_CTRL, 32'h0);
    run_cmd(8'h0c);
    check("adc from counter0", adc_channel0_select, c0_at);
    run_cmd(8'h0d);
    check("adc from counter1", adc_channel0_select, c1_at);
    v = rnd();
    axi_wr(`TSCX_OFF_LIT0, {16'h0000, v[15:0]});
    run_cmd(8'h0e);
    check("adc from literal", adc_channel0_select, v[15:0]);
    foreach (rsvd[i]) begin
      run_cmd(rsvd[i]);
      check("reserved adc", adc_channel0_select, v[15:0]);
      check("reserved delay", step_delay_enable, 1'b1);
      check("reserved pulses", compare_sync_pulse, 4'h0);
    end
    axi_rd(`TSCX_OFF_CMD);
    check("last reserved cmd", rd[7:0], rsvd[11]);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      a = (i == 0) ? 16'hffff : v[15:0];
      b = (i == 0) ? 16'h0002 : v[31:16];
      axi_wr(offs[i], {16'h0000, a});
      axi_wr(`TSCX_OFF_ADJ, {16'h0000, b});
      run_cmd({4'h1, 4'(i)});
      axi_rd(offs[i]);
      check("add result", rd, exp_sum(a, b));
      v = rnd();
      axi_wr(`TSCX_OFF_HOLD, {16'h0000, v[15:0]});
      run_cmd({4'h2, 4'(i + 8)});
      axi_rd(offs[i]);
      check("copy result", rd, {16'h0000, v[15:0]});
    end
    axi_wr(`TSCX_OFF_T0LIM, 32'd20);
    run_cmd(8'h08);
    check("timer0 wait", n >= 21 && n <= 24, 1'b1);
    axi_wr(`TSCX_OFF_T1LIM, 32'd35);
    run_cmd(8'h09);
    check("timer1 wait", n >= 36 && n <= 39, 1'b1);
    fork
      run_cmd(8'h0b);
      begin
        repeat (12) @(posedge aclk);
        axi_wr(`TSCX_OFF_CTRL, 32'h4);
      end
    join
    check("swt wait", n > 12, 1'b1);
    give_verdict();
  end
endmodule // tb_top
